// ---- verilog/and_clear_pkg.sv ----
// Purpose: Shared constants and carriers for the AND / bit-clear execution block
// Assumes: 12-bit instruction words, 8-bit data path, 32 file addresses
// Notes: Port address and timer address are parameters of the top module
package and_clear_pkg;
  localparam int unsigned INSN_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned BIT_W = 3;
  localparam logic [3:0] OP_AND_LITERAL = 4'he;
  localparam logic [3:0] OP_FILE_GROUP = 4'h1;
  localparam logic [1:0] SUB_AND_FILE = 2'h1;
  localparam logic [3:0] OP_CLEAR_BIT = 4'h4;
  localparam int unsigned OP_HI = 11;
  localparam int unsigned OP_LO = 8;
  localparam int unsigned SUB_HI = 7;
  localparam int unsigned SUB_LO = 6;
  localparam int unsigned DEST_POS = 5;
  localparam int unsigned BIT_HI = 7;
  localparam int unsigned BIT_LO = 5;
  localparam int unsigned ADDR_HI = 4;
  localparam int unsigned LIT_HI = 7;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;
  localparam logic [4:0] PORT_ADDR_DEFAULT = 5'h06;
  localparam logic [4:0] TIMER_ADDR_DEFAULT = 5'h01;

  typedef struct packed {
    logic valid;
    logic [INSN_W-1:0] word;
  } insn_type;

  typedef struct packed {
    logic enable;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } file_write_type;
endpackage : and_clear_pkg

// ---- verilog/and_and_bit_clear_exec.sv ----
// Purpose: Executes the literal AND, file AND and file bit clear instructions
// Assumes: One instruction per clock; file read data is combinational from the address
// Notes: Other opcodes leave zero flag and file untouched; the accumulator takes acc_load_data_in when acc_load_in is set and no AND writes it
// Overview of operation
// (RULE1) Opcode 1110 ANDs the accumulator with the low eight instruction bits.
// (RULE2) The literal AND writes only the accumulator and updates zero, in one cycle.
// (RULE3) Encoding 0001 01df ffff ANDs accumulator with file f, result to acc if d=0 else to f.
// (RULE4) Encoding 0100 bbbf ffff clears bit b of file f in one cycle, flags untouched.
// (RULE5) File AND or bit clear on the port register takes the operand from the pin levels.
// (RULE6) A write of the timer register by these ops clears the prescaler if assigned to it.
// (RULE7) Zero is set when all eight result bits are zero and cleared otherwise.
`timescale 1ns/100ps
`default_nettype none
module and_and_bit_clear_exec #(
  parameter logic [4:0] PORT_ADDR = and_clear_pkg::PORT_ADDR_DEFAULT,
  parameter logic [4:0] TIMER_ADDR = and_clear_pkg::TIMER_ADDR_DEFAULT
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Instruction from decoder
  input wire and_clear_pkg::insn_type insn_in,
  // File register read side
  output logic [and_clear_pkg::ADDR_W-1:0] file_read_addr_out,
  input wire logic [and_clear_pkg::DATA_W-1:0] file_read_data_in,
  input wire logic [and_clear_pkg::DATA_W-1:0] port_pins_in,
  // File register write side
  output and_clear_pkg::file_write_type file_write_out,
  // Timer prescaler
  input wire logic prescaler_on_timer_in,
  output logic prescaler_clear_out,
  // Accumulator write-back from the other instructions of the core
  input wire logic acc_load_in,
  input wire logic [and_clear_pkg::DATA_W-1:0] acc_load_data_in,
  // Core state
  output logic [and_clear_pkg::DATA_W-1:0] acc_out,
  output logic zero_out
);
  import and_clear_pkg::*;

  // Registered state
  logic [DATA_W-1:0] acc;
  logic zero;
  file_write_type file_write;
  logic prescaler_clear;

  // Next values
  logic [DATA_W-1:0] next_acc;
  logic next_zero;
  file_write_type next_file_write;
  logic next_prescaler_clear;

  // Decoded fields
  logic [3:0] opcode;
  logic [1:0] sub_op;
  logic dest_file;
  logic [BIT_W-1:0] bit_index;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] literal;

  // Operand and results
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] and_value;
  logic [DATA_W-1:0] cleared_value;

  // Instruction strobes
  logic is_and_literal;
  logic is_and_file;
  logic is_clear_bit;
  logic acc_written;
  logic file_written;

  // Zero test shared by both AND forms
  function automatic logic all_zero(input logic [DATA_W-1:0] value);
    return value == '0; // RULE7
  endfunction : all_zero

  // One-hot mask of the bit that the clear removes
  function automatic logic [DATA_W-1:0] bit_mask(input logic [BIT_W-1:0] index);
    logic [DATA_W-1:0] mask;
    mask = '0;
    mask[index] = 1'b1;
    return mask;
  endfunction : bit_mask

  // Both file-writing ops share the timer side effect
  function automatic logic hits_timer(
      input logic [ADDR_W-1:0] target,
      input logic assigned
  );
    return target == TIMER_ADDR && assigned; // RULE6
  endfunction : hits_timer

  // Write packet for the file owner
  function automatic file_write_type make_write(
      input logic [ADDR_W-1:0] target,
      input logic [DATA_W-1:0] value
  );
    file_write_type packet;
    packet.enable = 1'b1;
    packet.addr = target;
    packet.data = value;
    return packet;
  endfunction : make_write

  // Field split of the instruction word
  assign opcode = insn_in.word[OP_HI:OP_LO];
  assign sub_op = insn_in.word[SUB_HI:SUB_LO];
  assign dest_file = insn_in.word[DEST_POS];
  assign bit_index = insn_in.word[BIT_HI:BIT_LO];
  assign addr = insn_in.word[ADDR_HI:0];
  assign literal = insn_in.word[LIT_HI:0];
  assign file_read_addr_out = addr;

  // Instruction decode
  assign is_and_literal = insn_in.valid && opcode == OP_AND_LITERAL; // RULE1
  assign is_and_file = insn_in.valid
    && opcode == OP_FILE_GROUP
    && sub_op == SUB_AND_FILE; // RULE3
  assign is_clear_bit = insn_in.valid && opcode == OP_CLEAR_BIT; // RULE4
  assign acc_written = is_and_literal || (is_and_file && !dest_file); // RULE2 RULE3
  assign file_written = (is_and_file && dest_file) || is_clear_bit; // RULE3 RULE4

  // Pins, not the latch, so read-modify-write sees what is really there
  assign operand = (addr == PORT_ADDR) ? port_pins_in : file_read_data_in; // RULE5

  // Datapath results
  assign and_value = acc & (is_and_literal ? literal : operand); // RULE1 RULE3
  assign cleared_value = operand & ~bit_mask(bit_index); // RULE4

  // Accumulator and zero flag
  always_comb begin
    next_acc = acc;
    next_zero = zero;
    if (acc_written) begin
      next_acc = and_value; // RULE1 RULE2 RULE3
    end else if (acc_load_in) begin
      // Other instructions' result; an AND into the accumulator wins
      next_acc = acc_load_data_in;
    end
    if (is_and_literal || is_and_file) begin
      next_zero = all_zero(and_value); // RULE2 RULE7
    end
  end

  // File write port
  always_comb begin
    next_file_write = '0;
    if (is_and_file && dest_file) begin
      next_file_write = make_write(addr, and_value); // RULE3
    end else if (is_clear_bit) begin
      next_file_write = make_write(addr, cleared_value); // RULE4
    end
  end

  // Prescaler clear strobe
  always_comb begin
    next_prescaler_clear = 1'b0;
    if (file_written) begin
      next_prescaler_clear = hits_timer(addr, prescaler_on_timer_in); // RULE6
    end
  end

  // Accumulator registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      acc <= ACC_RESET;
      zero <= ZERO_RESET;
    end else begin
      acc <= next_acc;
      zero <= next_zero;
    end
  end

  // Writes are registered; the file sees them one edge later
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      file_write <= '0;
    end else begin
      file_write <= next_file_write;
    end
  end

  // One-cycle pulse towards the prescaler
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prescaler_clear <= 1'b0;
    end else begin
      prescaler_clear <= next_prescaler_clear;
    end
  end

  // Outputs

  assign acc_out = acc;
  assign zero_out = zero;
  assign file_write_out = file_write;
  assign prescaler_clear_out = prescaler_clear;
endmodule : and_and_bit_clear_exec
`default_nettype wire

// ---- verif/and_clear_asserts.sv ----
// Purpose: Checker for the AND and bit-clear block
// Assumes: Default port and timer addresses
// Notes: Bound to the top module
`timescale 1ns/100ps
`default_nettype none
module and_clear_chk import and_clear_pkg::*; (
  input wire logic clk_in, rst_in, prescaler_on_timer_in, prescaler_clear_out, zero_out,
  input wire logic acc_load_in,
  input wire logic [7:0] acc_load_data_in,
  input wire insn_type insn_in,
  input wire logic [7:0] file_read_data_in, port_pins_in, acc_out,
  input wire file_write_type file_write_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire logic [11:0] w = insn_in.word;
  wire logic lit = insn_in.valid && w[11:8] == 4'he;
  wire logic af = insn_in.valid && w[11:6] == 6'h05;
  wire logic bc = insn_in.valid && w[11:8] == 4'h4;
  // Pins, not latch, for the port
  wire logic [7:0] op = w[4:0] == 5'h06 ? port_pins_in : file_read_data_in;
  a_lit_and: assert property (lit |=> acc_out == $past(acc_out & w[7:0]))
    else $error("literal and");
  a_lit_only: assert property (lit |=> !file_write_out.enable)
    else $error("literal wrote file");
  a_and_acc: assert property (af && !w[5] |=> acc_out == $past(acc_out & op))
    else $error("file and to acc");
  a_and_file: assert property (af && w[5] |=> file_write_out ==
    {1'b1, $past(w[4:0]), $past(acc_out & op)} && $stable(acc_out)) else $error("file and");
  a_zero_flag: assert property (lit || af |=> zero_out == ($past(acc_out &
    (lit ? w[7:0] : op)) == 8'h00)) else $error("zero flag");
  a_clr_bit: assert property (bc |=> file_write_out == {1'b1, $past(w[4:0]),
    $past(op & ~(8'h01 << w[7:5]))} && $stable(zero_out)) else $error("bit clear");
  a_presc_clr: assert property ((af && w[5] || bc) && w[4:0] == 5'h01 |=>
    prescaler_clear_out == $past(prescaler_on_timer_in)) else $error("prescaler");
  a_idle_hold: assert property (!insn_in.valid && !acc_load_in |=> $stable(acc_out) &&
    !file_write_out.enable && !prescaler_clear_out) else $error("idle change");
  a_acc_load: assert property (acc_load_in && !lit && !(af && !w[5]) |=>
    acc_out == $past(acc_load_data_in)) else $error("acc load");
  a_no_timer: assert property ((af || bc) && w[4:0] != 5'h01 |=>
    !prescaler_clear_out) else $error("stray prescaler clear");
  c_zero_clear: cover property (lit && (acc_out & w[7:0]) != 8'h00);
  c_lit: cover property (lit);
  c_and: cover property (af && w[5]);
  c_clr: cover property (bc && prescaler_on_timer_in);
endmodule : and_clear_chk
bind and_and_bit_clear_exec and_clear_chk chk (.*);
`default_nettype wire

// ---- verif/and_and_bit_clear_exec_bench.sv ----
// Purpose: Bench for the AND and bit-clear block
// Assumes: Accumulator preloaded through the write-back port
// Notes: Inputs change at the falling edge
`timescale 1ns/100ps
`default_nettype none
module and_and_bit_clear_exec_bench;
  import and_clear_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  insn_type insn_in = '0;
  logic [7:0] fd = 8'h00;
  logic [7:0] pins = 8'h00;
  logic tmr = 1'b0;
  logic [4:0] ra;
  file_write_type fw;
  logic [7:0] acc;
  logic zero, pclr;
  logic ld = 1'b0;
  logic [7:0] ldd = 8'h00;
  int errors = 0;
  int checks = 0;
  always #2.5 clk_in = ~clk_in;
  and_and_bit_clear_exec dut (.clk_in(clk_in), .rst_in(rst_in), .insn_in(insn_in),
    .file_read_addr_out(ra), .file_read_data_in(fd), .port_pins_in(pins),
    .file_write_out(fw), .prescaler_on_timer_in(tmr), .prescaler_clear_out(pclr),
    .acc_load_in(ld), .acc_load_data_in(ldd), .acc_out(acc), .zero_out(zero));
  task load(input logic [7:0] v);
    @(negedge clk_in);
    ld = 1'b1;
    ldd = v;
    @(negedge clk_in);
    ld = 1'b0;
    chk({6'h0, acc}, {6'h0, v});
  endtask : load
  task chk(input logic [13:0] g, input logic [13:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task run(input logic [11:0] w);
    @(negedge clk_in);
    insn_in = {1'b1, w};
    #1 chk({9'h0, ra}, {9'h0, w[4:0]});
    @(negedge clk_in);
    insn_in.valid = 1'b0;
  endtask : run
  task t_lit;
    run(12'he5f);
    chk({4'h0, acc, zero, pclr}, 14'h0002);
    chk(fw, 14'h0000);
    $display("lit done");
  endtask : t_lit
  task t_clr;
    for (int b = 0; b < 8; b++) begin
      fd = 8'hc7;
      pins = 8'h5a;
      tmr = b[0];
      run({4'h4, b[2:0], 5'h01});
      chk(fw, {1'b1, 5'h01, 8'hc7 & ~(8'h01 << b)});
      chk({13'h1, pclr}, {13'h1, b[0]});
      run({4'h4, b[2:0], 5'h06});
      chk(fw, {1'b1, 5'h06, 8'h5a & ~(8'h01 << b)});
    end
    $display("clear done");
  endtask : t_clr
  task t_file;
    run(12'h161);
    chk(fw, {1'b1, 5'h01, 8'h00});
    chk({4'h0, acc, zero, pclr}, 14'h0003);
    run(12'h141);
    chk({fw, pclr} >> 1, 14'h0000);
    $display("file done");
  endtask : t_file
  task t_load_lit;
    load(8'ha3);
    run(12'he5f);
    chk({4'h0, acc, zero, pclr}, {4'h0, 8'h03, 2'b00});
    run(12'he00);
    chk({4'h0, acc, zero, pclr}, {4'h0, 8'h00, 2'b10});
    $display("literal load done");
  endtask : t_load_lit
  task t_file_acc;
    load(8'h17);
    fd = 8'h3c;
    tmr = 1'b0;
    run(12'h143);
    chk({4'h0, acc, zero, pclr}, {4'h0, 8'h14, 2'b00});
    chk(fw, 14'h0000);
    run(12'h163);
    chk(fw, {1'b1, 5'h03, 8'h14});
    chk({6'h0, acc}, {6'h0, 8'h14});
    fd = 8'hff;
    pins = 8'h0f;
    run(12'h146);
    chk({6'h0, acc}, {6'h0, 8'h04});
    run(12'h166);
    chk(fw, {1'b1, 5'h06, 8'h04});
    fd = 8'h00;
    run(12'h161);
    chk(fw, {1'b1, 5'h01, 8'h00});
    chk({4'h0, acc, zero, pclr}, {4'h0, 8'h04, 2'b10});
    $display("file acc done");
  endtask : t_file_acc
  task t_refused;
    tmr = 1'b1;
    run(12'h5e1);
    chk({fw, pclr} >> 1, 14'h0000);
    chk({4'h0, acc, zero, pclr}, {4'h0, 8'h04, 2'b10});
    @(negedge clk_in);
    insn_in = {1'b0, 12'he00};
    @(negedge clk_in);
    chk({4'h0, acc, zero, pclr}, {4'h0, 8'h04, 2'b10});
    $display("refused done");
  endtask : t_refused
  task t_reset;
    @(negedge clk_in);
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    chk({4'h0, acc, zero, pclr}, 14'h0000);
    chk(fw, 14'h0000);
    run(12'hef0);
    chk({4'h0, acc, zero, pclr}, 14'h0002);
    $display("reset done");
  endtask : t_reset
  task end_of_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (10) @(negedge clk_in);
    rst_in = 1'b0;
    chk({4'h0, acc, zero, pclr}, 14'h0000);
    t_lit;
    t_clr;
    t_file;
    t_load_lit;
    t_file_acc;
    t_refused;
    t_reset;
    end_of_test;
  end
endmodule : and_and_bit_clear_exec_bench
`default_nettype wire
